/* File: include/rtx_defines.vh */
// Constants of the exception sequencing unit
`ifndef RTX_DEFINES_VH
`define RTX_DEFINES_VH
// Module stop value loaded at reset release
`define RTX_MSTOP_RESET 16'h3FFF
// Interrupt mode select codes
`define RTX_MODE0 2'h0
`define RTX_MODE2 2'h2
// Condition code layout: mask bit 7, user bit 6
`define RTX_CCR_I 7
`define RTX_CCR_UI 6
// Extended control layout: trace bit 7, mask level bits 2..0
`define RTX_EXR_T 7
`define RTX_CCR_RESET 8'h80
`define RTX_EXR_RESET 8'h87
// Vector numbers
`define RTX_VEC_POR 7'h00
`define RTX_VEC_MAN 7'h01
`define RTX_VEC_TRACE 7'h05
`define RTX_VEC_NMI 7'h07
`define RTX_VEC_TRAP 7'h08
`define RTX_VEC_IRQ 7'h10
// Register offsets of the plain register port
`define RTX_REG_CTRL 4'h0
`define RTX_REG_CCR 4'h1
`define RTX_REG_EXR 4'h2
`define RTX_REG_STAT 4'h3
`define RTX_REG_MSTOP 4'h4
`define RTX_REG_PRIO 4'h5
`define RTX_REG_SENSE 4'h6
`define RTX_REG_IEN 4'h7
`define RTX_REG_IFLG 4'h8
// Least reset hold times for the far side
`define RTX_RES_HOLD_MS 20
`define RTX_RES_HOLD_STATES 20
`endif

/* File: src/rtx_unit.v */
// Reset, trace, trap and interrupt exception sequencing unit
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// ============================================================
// How it works
// RULE1 - Reset outranks every other exception
// RULE2 - Reset low halts; release starts processing
// RULE3 - Interrupt pin level classifies reset type
// RULE4 - Manual reset keeps bus and port state
// RULE5 - Manual reset returns pins to ports
// RULE6 - Watchdog overflow resets, either type
// RULE7 - Source holds reset low long enough
// RULE8 - Release clears trace, sets both masks
// RULE9 - Fetch reset vector into program counter
// RULE10 - Mode zero after any reset
// RULE11 - No interrupt before first instruction
// RULE12 - Module stop loads 3FFF on release
// RULE13 - Trace only in mode two
// RULE14 - Trace after each instruction when set
// RULE15 - Trace entry sets mask, clears trace
// RULE16 - Interrupts allowed inside trace handler
// RULE17 - No trace after return instruction
// RULE18 - Trap takes one of four vectors
// RULE19 - Trap sets mask; mode two clears trace
// RULE20 - Word accesses force low address bit
// RULE21 - Nonmaskable is level eight, always accepted
// RULE22 - Nine inputs with selectable sensing
// RULE23 - Priority: reset, trace, interrupt, trap
// RULE24 - Push state, update masks, then vector
// RULE25 - Mode select codes 00 and 10 only
// RULE26 - Reset pin synchronised before release edge
// ============================================================
`include "rtx_defines.vh"

module rtx_unit #(
  parameter NIRQ = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // External pins
  input wire ext_reset_pin_n,
  input wire nmi_pin,
  input wire [NIRQ-1:0] ext_irq_pins,
  input wire wdt_overflow,
  input wire wdt_manual,
  // CPU sequencing handshake
  input wire insn_done,
  input wire insn_is_rte,
  input wire insn_is_mask_op,
  input wire trap_req,
  input wire [1:0] trap_num,
  input wire [2:0] int_level,
  input wire int_req,
  input wire [6:0] int_vec,
  input wire [31:0] cpu_addr,
  input wire cpu_word_access,
  input wire [7:0] rte_ccr,
  input wire [7:0] rte_exr,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Sequencing outputs
  output reg cpu_halt,
  output reg periph_init,
  output reg busport_init,
  output reg pins_to_port,
  output reg exc_start,
  output reg [6:0] exc_vector,
  output reg exc_push,
  output reg [31:0] mem_addr,
  output reg [7:0] cond_code_reg,
  output reg [7:0] extended_ctrl_reg,
  output reg [15:0] module_stop_reg,
  output reg [1:0] int_mode
);

  // ==========================================================
  // State machine codes
  localparam [3:0] ST_RESET = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_FIRST = 4'b1000;

  // ==========================================================
  // Pin synchronisers, two flops each
  reg [1:0] res_sync_q;
  reg [1:0] nmi_sync_q;
  reg [NIRQ-1:0] irq_s1_q;
  reg [NIRQ-1:0] irq_s2_q;
  reg [NIRQ-1:0] irq_prev_q;
  reg nmi_prev_q;
  reg res_prev_q;
  reg [3:0] state_q;
  reg manual_q;            // Latched reset type
  reg nmi_edge_sel_q;      // 1 = rising edge
  reg [15:0] sense_q;      // Two bits per maskable input
  reg [NIRQ-1:0] ien_q;    // Input enables
  reg [NIRQ-1:0] iflg_q;   // Sticky request flags
  reg nmi_pend_q;
  reg [23:0] prio_q;       // Three bits per maskable input
  reg wdt_q;
  reg [1:0] mode_sel_q;
  reg trap_pend_q;         // Trap held behind a trace or interrupt
  reg [1:0] trap_num_q;    // Vector select of the held trap

  // Two-flop synchronisers for the reset, nonmaskable and maskable pins
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_sync_q <= 2'h0;
      // Rest level of the pin, so no false edge and no manual type after reset
      nmi_sync_q <= 2'h3;
      irq_s1_q <= {NIRQ{1'b1}};
      irq_s2_q <= {NIRQ{1'b1}};
    end
    else
    begin
      res_sync_q <= {res_sync_q[0], ext_reset_pin_n}; // RULE26
      nmi_sync_q <= {nmi_sync_q[0], nmi_pin};
      irq_s1_q <= ext_irq_pins;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Release edge of the synchronised pin
  wire res_low = ~res_sync_q[1];
  wire res_rise = res_sync_q[1] & ~res_prev_q; // RULE2
  wire nmi_hit = nmi_edge_sel_q ? (nmi_sync_q[1] & ~nmi_prev_q)
                                : (~nmi_sync_q[1] & nmi_prev_q); // RULE22

  // ==========================================================
  // Maskable input detection, one per input
  wire [NIRQ-1:0] irq_set;
  wire [NIRQ-1:0] irq_prio_ok;
  genvar gi;
  generate
    for (gi = 0; gi < NIRQ; gi = gi + 1)
    begin : g_irq
      wire [1:0] sc = sense_q[2*gi+1:2*gi];
      wire fall = irq_prev_q[gi] & ~irq_s2_q[gi];
      wire rise = ~irq_prev_q[gi] & irq_s2_q[gi];
      // Low level, falling, rising or both edges
      assign irq_set[gi] = (sc == 2'h0) ? ~irq_s2_q[gi] :
                           (sc == 2'h1) ? fall :
                           (sc == 2'h2) ? rise : (fall | rise); // RULE22
      // Level must exceed the mask level in mode two
      assign irq_prio_ok[gi] = prio_q[3*gi+2:3*gi] > extended_ctrl_reg[2:0]; // RULE21
    end
  endgenerate

  // Candidate maskable request, lowest eligible index wins; levels are not compared
  reg irq_hit;
  reg [2:0] irq_idx;
  integer k;
  always @*
  begin
    irq_hit = 1'b0;
    irq_idx = 3'h0;
    for (k = NIRQ - 1; k >= 0; k = k - 1)
    begin
      if (iflg_q[k] & ien_q[k] & ((int_mode == `RTX_MODE0) ? 1'b1 : irq_prio_ok[k]))
      begin
        irq_hit = 1'b1;
        irq_idx = k[2:0];
      end
    end
  end

  // Mask bit gates in mode zero; level compare gates in mode two
  wire mask_open = (int_mode == `RTX_MODE0) ? ~cond_code_reg[`RTX_CCR_I] : 1'b1; // RULE25
  wire ext_int = int_req & ((int_mode == `RTX_MODE0) ? 1'b1 : int_level > extended_ctrl_reg[2:0]);
  // Nonmaskable ignores both masks; taken at an instruction end that is not a mask operation
  wire int_ok = nmi_pend_q | ((irq_hit | ext_int) & mask_open); // RULE21
  wire trace_ok = (int_mode == `RTX_MODE2) & extended_ctrl_reg[`RTX_EXR_T]
                  & ~insn_is_rte; // RULE13 RULE14 RULE17
  // A fresh trap request wins over a held one
  wire [1:0] trap_sel = trap_req ? trap_num : trap_num_q;

  // ==========================================================
  // Main exception sequencer
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_RESET;
      manual_q <= 1'b0;
      res_prev_q <= 1'b0;
      nmi_prev_q <= 1'b1;
      irq_prev_q <= {NIRQ{1'b1}};
      wdt_q <= 1'b0;
      cpu_halt <= 1'b1;
      periph_init <= 1'b1;
      busport_init <= 1'b1;
      pins_to_port <= 1'b0;
      exc_start <= 1'b0;
      exc_vector <= `RTX_VEC_POR;
      exc_push <= 1'b0;
      cond_code_reg <= `RTX_CCR_RESET;
      extended_ctrl_reg <= `RTX_EXR_RESET;
      module_stop_reg <= `RTX_MSTOP_RESET;
      int_mode <= `RTX_MODE0;
      mode_sel_q <= `RTX_MODE0;
      nmi_edge_sel_q <= 1'b0;
      sense_q <= 16'h0000;
      ien_q <= {NIRQ{1'b0}};
      iflg_q <= {NIRQ{1'b0}};
      nmi_pend_q <= 1'b0;
      prio_q <= {NIRQ{3'h7}};
      trap_pend_q <= 1'b0;
      trap_num_q <= 2'h0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      res_prev_q <= res_sync_q[1];
      nmi_prev_q <= nmi_sync_q[1];
      irq_prev_q <= irq_s2_q;
      wdt_q <= wdt_overflow;
      exc_start <= 1'b0;
      exc_push <= 1'b0;
      periph_init <= 1'b0;
      busport_init <= 1'b0;
      pins_to_port <= 1'b0;
      // Sticky flags: set wins over a software clear
      if (reg_wr && reg_addr == `RTX_REG_IFLG)
        iflg_q <= (iflg_q & reg_wdata[NIRQ-1:0]) | irq_set;
      else
        iflg_q <= iflg_q | irq_set;
      if (nmi_hit)
        nmi_pend_q <= 1'b1;
      // Reset pin or watchdog overflow outranks everything
      if (res_low || (wdt_overflow && !wdt_q)) // RULE1 RULE6
      begin
        state_q <= ST_RESET;
        cpu_halt <= 1'b1; // RULE2
        // Pin level taken during reset, watchdog carries its own type
        manual_q <= res_low ? ~nmi_sync_q[1] : wdt_manual; // RULE3 RULE6
        trap_pend_q <= 1'b0;
        nmi_pend_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_RESET:
          begin
            if (res_rise || !res_low)
            begin
              // Initialise CPU and peripherals on release
              periph_init <= 1'b1; // RULE4
              busport_init <= ~manual_q; // RULE4
              pins_to_port <= manual_q; // RULE5
              cond_code_reg[`RTX_CCR_I] <= 1'b1; // RULE8
              extended_ctrl_reg[`RTX_EXR_T] <= 1'b0; // RULE8
              extended_ctrl_reg[2:0] <= 3'h7; // RULE8
              module_stop_reg <= `RTX_MSTOP_RESET; // RULE12
              int_mode <= `RTX_MODE0; // RULE10
              mode_sel_q <= `RTX_MODE0;
              iflg_q <= {NIRQ{1'b0}};
              nmi_pend_q <= 1'b0;
              exc_vector <= manual_q ? `RTX_VEC_MAN : `RTX_VEC_POR; // RULE9
              exc_start <= 1'b1; // RULE9
              state_q <= ST_FETCH;
            end
          end
          ST_FETCH:
          begin
            cpu_halt <= 1'b0;
            state_q <= ST_FIRST;
          end
          ST_FIRST:
          begin
            // Interrupt requests stay pending, trap requests are dropped, and none is taken until the first instruction ends
            if (insn_done) // RULE11
              state_q <= ST_RUN;
          end
          ST_RUN:
          begin
            // A trap that loses to a trace or interrupt is kept, not dropped
            if (trap_req)
            begin
              trap_pend_q <= 1'b1; // RULE23
              trap_num_q <= trap_num;
            end
            if (insn_done && trace_ok) // RULE23
            begin
              exc_vector <= `RTX_VEC_TRACE;
              exc_start <= 1'b1;
              exc_push <= 1'b1; // RULE24
              cond_code_reg[`RTX_CCR_I] <= 1'b1; // RULE15
              extended_ctrl_reg[`RTX_EXR_T] <= 1'b0; // RULE15
            end
            else if (insn_done && !insn_is_mask_op && int_ok) // RULE16 RULE23
            begin
              exc_start <= 1'b1;
              exc_push <= 1'b1; // RULE24
              cond_code_reg[`RTX_CCR_I] <= 1'b1;
              if (int_mode == `RTX_MODE2)
                extended_ctrl_reg[`RTX_EXR_T] <= 1'b0;
              if (nmi_pend_q)
              begin
                exc_vector <= `RTX_VEC_NMI;
                nmi_pend_q <= 1'b0;
              end
              else if (irq_hit)
              begin
                exc_vector <= `RTX_VEC_IRQ + {4'h0, irq_idx};
                // Edge modes clear on acceptance; level clears if input high
                if (sense_q[2*irq_idx+:2] != 2'h0 || irq_s2_q[irq_idx])
                  iflg_q[irq_idx] <= irq_set[irq_idx];
              end
              else
                exc_vector <= int_vec;
            end
            else if (trap_req || trap_pend_q) // RULE18 RULE23
            begin
              exc_vector <= `RTX_VEC_TRAP + {5'h00, trap_sel}; // RULE18
              trap_pend_q <= 1'b0;
              exc_start <= 1'b1;
              exc_push <= 1'b1; // RULE24
              cond_code_reg[`RTX_CCR_I] <= 1'b1; // RULE19
              if (int_mode == `RTX_MODE2)
                extended_ctrl_reg[`RTX_EXR_T] <= 1'b0; // RULE19
            end
            else if (insn_done && insn_is_rte)
            begin
              // Restores stacked trace bit so tracing resumes
              cond_code_reg <= rte_ccr; // RULE16
              extended_ctrl_reg <= rte_exr;
            end
          end
          default:
            state_q <= ST_RESET;
        endcase
        // Software writes to the control registers
        if (reg_wr)
        begin
          case (reg_addr)
            `RTX_REG_CTRL:
            begin
              // Prohibited codes are refused
              if (reg_wdata[1:0] == `RTX_MODE0 || reg_wdata[1:0] == `RTX_MODE2) // RULE25
              begin
                mode_sel_q <= reg_wdata[1:0];
                int_mode <= reg_wdata[1:0];
              end
              nmi_edge_sel_q <= reg_wdata[2];
            end
            `RTX_REG_CCR: cond_code_reg <= reg_wdata[7:0];
            `RTX_REG_EXR: extended_ctrl_reg <= reg_wdata[7:0];
            `RTX_REG_MSTOP: module_stop_reg <= reg_wdata;
            `RTX_REG_PRIO: prio_q[15:0] <= reg_wdata;
            `RTX_REG_SENSE: sense_q <= reg_wdata;
            `RTX_REG_IEN: ien_q <= reg_wdata[NIRQ-1:0];
            default: ;
          endcase
        end
      end
      // Read data one cycle after the strobe
      if (reg_rd)
      begin
        case (reg_addr)
          `RTX_REG_CTRL: reg_rdata <= {13'h0000, nmi_edge_sel_q, mode_sel_q};
          `RTX_REG_CCR: reg_rdata <= {8'h00, cond_code_reg};
          `RTX_REG_EXR: reg_rdata <= {8'h00, extended_ctrl_reg};
          `RTX_REG_STAT: reg_rdata <= {11'h000, nmi_pend_q, manual_q, state_q[2:0]};
          `RTX_REG_MSTOP: reg_rdata <= module_stop_reg;
          `RTX_REG_PRIO: reg_rdata <= prio_q[15:0];
          `RTX_REG_SENSE: reg_rdata <= sense_q;
          `RTX_REG_IEN: reg_rdata <= {8'h00, ien_q};
          `RTX_REG_IFLG: reg_rdata <= {8'h00, iflg_q};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      else
        reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Word and longword accesses force address bit zero low
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_addr <= 32'h00000000;
    else
      mem_addr <= {cpu_addr[31:1], cpu_addr[0] & ~cpu_word_access}; // RULE20
  end

endmodule

/* File: testbench/rtx_reset_src.sv */
// Model of the external reset source and interrupt pins
`timescale 1ns/1ps
// ============================================================
// Reset source
module rtx_reset_src #(
  parameter HOLD = 24
) (
  // Clock
  input wire sys_clk,
  // Pins; interrupt pins rest high
  output logic ext_reset_pin_n = 1'b1,
  output logic nmi_pin = 1'b1,
  output logic [7:0] ext_irq_pins = 8'hFF
);
  // Set the type level, then hold the pin low for at least 20 states
  task hold_reset(input logic lvl);
    @(posedge sys_clk);
    nmi_pin <= lvl;
    ext_reset_pin_n <= 1'b0;
    repeat (HOLD) @(posedge sys_clk);
    ext_reset_pin_n <= 1'b1;
  endtask
  // Move the maskable pins
  task set_irq(input logic [7:0] v);
    @(posedge sys_clk);
    ext_irq_pins <= v;
  endtask
  // Move the nonmaskable pin
  task set_nmi(input logic lvl);
    @(posedge sys_clk);
    nmi_pin <= lvl;
  endtask
endmodule

/* File: testbench/rtx_unit_assertions.sv */
// Port-level assertions for the exception sequencing unit
`timescale 1ns/1ps
// ============================================================
// Checker
module rtx_unit_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Pins and sequencing inputs
  input wire ext_reset_pin_n,
  input wire nmi_pin,
  input wire insn_done,
  input wire insn_is_rte,
  input wire insn_is_mask_op,
  input wire trap_req,
  input wire [1:0] trap_num,
  input wire cpu_word_access,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input logic [15:0] reg_rdata,
  // Sequencing outputs
  input logic cpu_halt,
  input logic exc_start,
  input logic [6:0] exc_vector,
  input logic exc_push,
  input logic [31:0] mem_addr,
  input logic [7:0] cond_code_reg,
  input logic [7:0] extended_ctrl_reg,
  input logic [15:0] module_stop_reg,
  input logic [1:0] int_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Clean trap request: no competing instruction end or register write
  wire trap_go = trap_req && ext_reset_pin_n && !cpu_halt && !insn_done && !reg_wr;
  // Instruction end that must raise a trace
  wire trace_go = insn_done && !insn_is_rte && !insn_is_mask_op && !cpu_halt
    && int_mode == 2'h2 && extended_ctrl_reg[7];
  a_pin_halts: assert property (!ext_reset_pin_n [*4] |-> cpu_halt)
    else $error("halt missing while reset pin low");
  a_release_start: assert property ($rose(ext_reset_pin_n) |-> ##[1:4]
    (exc_start && cpu_halt) ##1 !cpu_halt) else $error("no reset entry after release");
  a_reset_type: assert property (exc_start && cpu_halt |->
    exc_vector == (nmi_pin ? 7'h00 : 7'h01)) else $error("wrong reset vector");
  a_release_init: assert property (exc_start && cpu_halt |-> cond_code_reg[7]
    && !extended_ctrl_reg[7] && int_mode == 2'h0 && module_stop_reg == 16'h3FFF)
    else $error("state not initialised at reset entry");
  a_trap_entry: assert property (trap_go |=> exc_start && exc_push && cond_code_reg[7]
    && exc_vector == {5'h02, $past(trap_num)}) else $error("trap entry wrong");
  a_trap_bits: assert property (trap_go |=> cond_code_reg[6] == $past(cond_code_reg[6])
    && extended_ctrl_reg[2:0] == $past(extended_ctrl_reg[2:0]) && extended_ctrl_reg[7] ==
    ($past(int_mode) == 2'h2 ? 1'b0 : $past(extended_ctrl_reg[7])))
    else $error("trap flag update wrong");
  a_trace_entry: assert property (trace_go |=> exc_start && exc_vector == 7'h05
    && cond_code_reg[7] && !extended_ctrl_reg[7]
    && extended_ctrl_reg[2:0] == $past(extended_ctrl_reg[2:0])) else $error("trace entry wrong");
  a_no_trace_m0: assert property (insn_done && int_mode == 2'h0 |=>
    !(exc_start && exc_vector == 7'h05)) else $error("trace in mode zero");
  a_no_trace_rte: assert property (insn_done && insn_is_rte |=>
    !(exc_start && exc_vector == 7'h05)) else $error("trace after return");
  a_word_align: assert property (cpu_word_access |=> !mem_addr[0])
    else $error("odd word address");
  a_mstop_read: assert property (reg_rd && reg_addr == 4'h4 |=>
    reg_rdata == $past(module_stop_reg)) else $error("module stop read wrong");
  a_mode_codes: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0] |=>
    int_mode == $past(int_mode)) else $error("prohibited mode code taken");
endmodule
bind rtx_unit rtx_unit_chk u_rtx_unit_chk (.*);

/* File: testbench/rtx_unit_tb_top.sv */
// Self-checking bench for the exception sequencing unit
`timescale 1ns/1ps
`define CHK(nm, e, a) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); \
    end \
  end
// ============================================================
// Bench top
module rtx_unit_tb_top;
  // Clock, reset, counters
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_bus = 0;
  int n_pin = 0;
  // Pins of the partner model
  logic ext_reset_pin_n, nmi_pin;
  logic [7:0] ext_irq_pins;
  // Bench inputs; the internal request port stays idle
  logic wdt_overflow = 1'b0, wdt_manual = 1'b0, insn_done = 1'b0, insn_is_rte = 1'b0;
  logic insn_is_mask_op = 1'b0, trap_req = 1'b0, int_req = 1'b0, cpu_word_access = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] trap_num = 2'h0;
  logic [2:0] int_level = 3'h0;
  logic [6:0] int_vec = 7'h00;
  logic [31:0] cpu_addr = 32'h00000000;
  logic [7:0] rte_ccr = 8'h00, rte_exr = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  // Design outputs
  logic [15:0] reg_rdata, module_stop_reg;
  logic cpu_halt, periph_init, busport_init, pins_to_port, exc_start, exc_push;
  logic [6:0] exc_vector;
  logic [31:0] mem_addr;
  logic [7:0] cond_code_reg, extended_ctrl_reg;
  logic [1:0] int_mode;
  rtx_unit #(.NIRQ(8)) u_rtx_unit (.*);
  rtx_reset_src u_rtx_reset_src (.*);
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Pulse counters and hang limit
  always @(posedge sys_clk)
  begin
    n_bus += (busport_init === 1'b1);
    n_pin += (pins_to_port === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One-cycle strobes, held across one sampling edge
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task ins(input logic return_from_exception, input logic trap, input logic [1:0] num);
    @(posedge sys_clk);
    insn_done <= ~trap | return_from_exception;
    insn_is_rte <= return_from_exception;
    trap_req <= trap;
    trap_num <= num;
    @(posedge sys_clk);
    insn_done <= 1'b0;
    insn_is_rte <= 1'b0;
    trap_req <= 1'b0;
  endtask
  // Bounded wait for an exception entry
  task wexc(input logic [6:0] v, input int lim);
    int n;
    n = 0;
    #1;
    while (exc_start !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("exc_vector", {1'b1, v}, {exc_start, exc_vector})
  endtask
  task quiet(input int lim);
    int hits;
    hits = 0;
    repeat (lim)
    begin
      #1;
      hits += (exc_start === 1'b1);
      @(posedge sys_clk);
    end
    `CHK("no_entry", 0, hits)
  endtask
  task pin_reset(input logic lvl);
    n_bus = 0;
    n_pin = 0;
    u_rtx_reset_src.hold_reset(lvl);
    wexc({6'h00, ~lvl}, 8);
    `CHK("periph_init", 1'b1, periph_init)
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("reset_kind", {lvl, ~lvl}, {n_bus > 0, n_pin > 0})
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("init", 3'h4, {cond_code_reg[7], int_mode})
    rd(4'h4, 16'h3FFF);
    rd(4'hF, 16'h0000);
    ins(1'b0, 1'b0, 2'h0);
    ins(1'b0, 1'b1, 2'h1);
    wexc(7'h09, 4);
    $display("test reset_values done");
    pin_reset(1'b1);
    `CHK("trace_flag", 1'b0, extended_ctrl_reg[7])
    u_rtx_reset_src.set_nmi(1'b0);
    quiet(8);
    ins(1'b0, 1'b0, 2'h0);
    ins(1'b0, 1'b0, 2'h0);
    wexc(7'h07, 6);
    pin_reset(1'b0);
    @(posedge sys_clk);
    wdt_manual <= 1'b1;
    wdt_overflow <= 1'b1;
    @(posedge sys_clk);
    wdt_overflow <= 1'b0;
    wexc(7'h01, 8);
    ins(1'b0, 1'b0, 2'h0);
    $display("test resets done");
    wr(4'h0, 16'h0003);
    `CHK("int_mode", 2'h0, int_mode)
    wr(4'h1, 16'h0040);
    wr(4'h2, 16'h0085);
    ins(1'b0, 1'b0, 2'h0);
    quiet(6);
    wr(4'h0, 16'h0002);
    `CHK("int_mode", 2'h2, int_mode)
    ins(1'b0, 1'b0, 2'h0);
    wexc(7'h05, 4);
    `CHK("flags", 6'h35, {cond_code_reg[7:6], extended_ctrl_reg[7], extended_ctrl_reg[2:0]})
    @(posedge sys_clk);
    rte_ccr <= 8'h40;
    rte_exr <= 8'h85;
    ins(1'b1, 1'b0, 2'h0);
    quiet(6);
    ins(1'b0, 1'b0, 2'h0);
    wexc(7'h05, 4);
    wr(4'h2, 16'h0085);
    // Instruction end and trap together: trace first, then the held trap
    @(posedge sys_clk);
    insn_done <= 1'b1;
    trap_req <= 1'b1;
    trap_num <= 2'h2;
    @(posedge sys_clk);
    insn_done <= 1'b0;
    trap_req <= 1'b0;
    wexc(7'h05, 4);
    @(posedge sys_clk);
    wexc(7'h0A, 4);
    repeat (8) @(posedge sys_clk);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h2, 16'h0085);
      ins(1'b0, 1'b1, k[1:0]);
      wexc(7'(8 + k), 4);
      `CHK("flags", 6'h35, {cond_code_reg[7:6], extended_ctrl_reg[7], extended_ctrl_reg[2:0]})
    end
    // Low level on input 0, enabled, level 7 above mask level 5
    u_rtx_reset_src.set_irq(8'hFE);
    wr(4'h7, 16'h0001);
    ins(1'b0, 1'b0, 2'h0);
    wexc(7'h10, 6);
    rd(4'h8, 16'h0001);
    $display("test trace_trap done");
    @(posedge sys_clk);
    cpu_addr <= 32'h00001001;
    cpu_word_access <= 1'b1;
    @(posedge sys_clk);
    cpu_word_access <= 1'b0;
    #1;
    `CHK("mem_addr", 32'h00001000, mem_addr)
    @(posedge sys_clk);
    #1;
    `CHK("mem_addr", 32'h00001001, mem_addr)
    $display("test word_access done");
    close_out();
  end
endmodule
